// File: hw/scc_pkg.sv
// Constants, symbol values and encoder functions of the special-character codec.
// Assumes symbol bit 9 is abcdei bit a (first on the line) and bit 0 is fghj bit j.
package scc_pkg;
   // Special-character codes on the parallel byte: low five bits x, high three y
   localparam logic [7:0] SC_COMMA = 8'h05;
   localparam logic [7:0] SC_IDLE = 8'h20;
   localparam logic [7:0] SC_RRDY = 8'h21;
   localparam logic [7:0] SC_EOF = 8'h22;
   localparam logic [7:0] SC_VIOL = 8'hE0;
   localparam logic [7:0] SC_KNEG = 8'hE1;
   localparam logic [7:0] SC_KPOS = 8'hE2;
   localparam logic [7:0] SC_RDERR = 8'hE4;

   // Data bytes used inside ordered sets
   localparam logic [7:0] D21_4 = 8'h95;
   localparam logic [7:0] D21_5 = 8'hB5;
   localparam logic [7:0] D10_2 = 8'h4A;

   // Ten-bit symbols
   localparam logic [9:0] K285_NEG = 10'h0FA;
   localparam logic [9:0] K285_POS = 10'h305;
   localparam logic [9:0] VIOL_NEG = 10'h278;
   localparam logic [9:0] VIOL_POS = 10'h187;
   localparam logic [9:0] RDERR_NEG = 10'h375;
   localparam logic [9:0] RDERR_POS = 10'h08A;
   localparam logic [9:0] SYM_D21_5 = 10'h2AA;
   localparam logic [9:0] SYM_D10_2 = 10'h155;

   // Field positions, counts and reset values
   localparam int EOF_BIT = 5;
   localparam int K_CODES = 12;
   localparam logic [4:0] X_K28 = 5'h1C;
   localparam logic [4:0] X_D7 = 5'h07;
   localparam logic [1:0] SEQ_FIRST = 2'h0;
   localparam logic [1:0] SEQ_SECOND = 2'h1;
   localparam logic RD_RESET = 1'b0;
   localparam logic [9:0] SYM_RESET = 10'h000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Transmit ordered-set tracking
   typedef enum logic [2:0] {
      TX_DATA = 3'b001,
      TX_IDLE = 3'b010,
      TX_RRDY = 3'b100
   } scc_tx_mode_t;

   // Six-bit codes for negative disparity entry
   localparam logic [5:0] SIX_NEG [0:31] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   // Four-bit codes for negative disparity entry
   localparam logic [3:0] FOUR_NEG [0:7] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
   localparam logic [3:0] FOUR_ALT = 4'h7;
   localparam logic [5:0] SIX_K28 = 6'h0F;
   // Extra special characters K23.7, K27.7, K29.7, K30.7
   localparam logic [7:0] K_EXTRA [0:3] = '{8'hF7, 8'hFB, 8'hFD, 8'hFE};

   // Disparity after a symbol: balanced keeps, otherwise sign of the excess
   function automatic logic scc_rd_after(input logic [9:0] sym, input logic rd);
      int n;
      n = $countones(sym);
      return (n == 5) ? rd : (n > 5);
   endfunction

   // Eight-to-ten encoder; k selects the special-character form
   function automatic logic [9:0] scc_encode(input logic [7:0] b, input logic k,
                                             input logic rd);
      logic [4:0] x;
      logic [2:0] y;
      logic [5:0] s6;
      logic [3:0] s4;
      logic k28;
      logic r0;
      logic r;
      logic alt;
      x = b[4:0];
      y = b[7:5];
      k28 = k && (x == X_K28);
      r0 = k28 ? 1'b0 : rd;
      s6 = k28 ? SIX_K28 : SIX_NEG[x];
      if (r0 && (($countones(s6) != 3) || (x == X_D7))) begin
         s6 = ~s6;
      end
      r = ($countones(s6) == 3) ? r0 : ($countones(s6) > 3);
      alt = (y == 3'h7) && (k || (!r && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                            (r && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
      s4 = alt ? FOUR_ALT : FOUR_NEG[y];
      if (r && (($countones(s4) != 2) || (y == 3'h3))) begin
         s4 = ~s4;
      end
      return (k28 && rd) ? ~{s6, s4} : {s6, s4};
   endfunction
endpackage : scc_pkg

// File: hw/scc_rx_if.sv
// Link between the codec top and its receive decoder.
// Assumes both ends run on the same byte-rate clock.
interface scc_rx_if;
   logic [9:0] symbol;
   logic [7:0] code;
   logic special;
   logic rd;

   modport dec (input symbol, output code, output special, output rd);
   modport top (output symbol, input code, input special, input rd);
endinterface : scc_rx_if

// File: hw/scc_rx_dec.sv
// Receive decoder: ten-bit symbol to byte, special flag and exception codes.
// Assumes one symbol per enabled clock, already on the byte-rate clock.
module scc_rx_dec (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Symbol in, code out
   scc_rx_if.dec rx
);
   import scc_pkg::*;

   logic rd_q, rd_d;
   logic [7:0] code_q, code_d;
   logic special_q, special_d;
   logic [9:0] hit_now, hit_other;

   // Table lookup: {found, special, byte}
   function automatic logic [9:0] scc_decode(input logic [9:0] sym, input logic rd);
      logic [9:0] res;
      logic [7:0] kb;
      res = {2'b00, BYTE_RESET};
      for (int i = 0; i < 256; i++) begin
         if (scc_encode(8'(i), 1'b0, rd) == sym) begin
            res = {2'b10, 8'(i)};
         end
      end
      for (int j = 0; j < K_CODES; j++) begin
         kb = (j < 8) ? {3'(j), X_K28} : K_EXTRA[j - 8];
         if (scc_encode(kb, 1'b1, rd) == sym) begin
            res = {2'b11, 8'(j)};
         end
      end
      return res;
   endfunction

   assign hit_now = scc_decode(rx.symbol, rd_q);
   assign hit_other = scc_decode(rx.symbol, ~rd_q);

   always_comb begin
      rd_d = scc_rd_after(rx.symbol, rd_q); // RULE19
      code_d = SC_VIOL;
      special_d = 1'b1;
      if (rx.symbol == K285_NEG) begin
         code_d = rd_q ? SC_KNEG : SC_COMMA; // RULE11 RULE5
      end else if (rx.symbol == K285_POS) begin
         code_d = rd_q ? SC_COMMA : SC_KPOS; // RULE13 RULE5
      end else if (hit_now[9]) begin
         code_d = hit_now[7:0]; // RULE17
         special_d = hit_now[8];
      end else if (hit_other[9]) begin
         code_d = SC_RDERR; // RULE15
      end else begin
         code_d = SC_VIOL; // RULE9
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_q <= RD_RESET;
         code_q <= BYTE_RESET;
         special_q <= 1'b0;
      end else if (ce) begin
         rd_q <= rd_d;
         code_q <= code_d;
         special_q <= special_d;
      end
   end

   assign rx.code = code_q;
   assign rx.special = special_q;
   assign rx.rd = rd_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_rx_kneg;
      ce && rx.symbol == K285_NEG && rd_q |=> special_q && code_q == SC_KNEG && rd_q;
   endproperty
   a_rx_kneg: assert property (p_rx_kneg) else $error("wrong report for -K28.5 at RD+"); // RULE11

   property p_rx_kpos;
      ce && rx.symbol == K285_POS && !rd_q |=> special_q && code_q == SC_KPOS && !rd_q;
   endproperty
   a_rx_kpos: assert property (p_rx_kpos) else $error("wrong report for +K28.5 at RD-"); // RULE13

   property p_rx_comma;
      ce && rx.symbol == K285_NEG && !rd_q |=> special_q && code_q == SC_COMMA;
   endproperty
   a_rx_comma: assert property (p_rx_comma) else $error("K28.5 not reported as C5.0"); // RULE5

   property p_rx_noset;
      special_q |-> code_q != SC_IDLE && code_q != SC_RRDY && code_q != SC_EOF;
   endproperty
   a_rx_noset: assert property (p_rx_noset) else $error("ordered-set code on receive"); // RULE5

   property p_rx_viol;
      ce && !hit_now[9] && !hit_other[9] |=> special_q && code_q == SC_VIOL;
   endproperty
   a_rx_viol: assert property (p_rx_viol) else $error("invalid symbol not flagged"); // RULE9

   property p_rx_rderr;
      ce && rx.symbol != K285_NEG && rx.symbol != K285_POS &&
      !hit_now[9] && hit_other[9] |=> special_q && code_q == SC_RDERR;
   endproperty
   a_rx_rderr: assert property (p_rx_rderr) else $error("disparity error not flagged"); // RULE15
endmodule // scc_rx_dec

// File: hw/scc_codec.sv
// Special-character codec top: transmit encoder with ordered sets and receive decoder.
// Assumes host byte, select and violation request are on clk; rx_symbol is on clk too.

// Function
// RULE1: C0.1 for one byte sends negative K28.5 whatever the disparity.
// RULE2: C0.1 held sends -K28.5, D21.4, D21.5, D21.5 repeating.
// RULE3: Host holds ordered-set codes four bytes or multiples, else truncated.
// RULE4: C1.1 sends -K28.5 once, held sends -K28.5, D21.4, D10.2, D10.2.
// RULE5: Receiver reports K28.5 as C5.0, C1.7 or C2.7, never ordered sets.
// RULE6: C2.1 sends K28.5 with polarity from current running disparity.
// RULE7: Character after C2.1 gets low bit 0 at RD+, 1 at RD-.
// RULE8: C0.7 sends a disparity-correct violation, same as violation request input.
// RULE9: Receiver outputs C0.7 only for symbols found in no table.
// RULE10: C1.7 sends negative K28.5 ignoring running disparity.
// RULE11: Receiver gives C1.7 for -K28.5 at RD+, else C5.0.
// RULE12: C2.7 sends positive K28.5 ignoring running disparity.
// RULE13: Receiver gives C2.7 for +K28.5 at RD-.
// RULE14: C4.7 sends a violation marking a disparity error to the far end.
// RULE15: Receiver gives C4.7 for valid symbol with wrong disparity.
// RULE16: Host issues only defined special-character codes.
// RULE17: Code Cx.y has x in low five bits, y in high three.
// RULE18: Byte is a special code only while the select input is high.
// RULE19: Both sides keep running disparity, negative after reset, updated per symbol.
// RULE20: Forced and violation symbols update disparity by what was sent.
module scc_codec (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Transmit parallel side
   input wire logic [7:0] tx_byte,
   input wire logic special_char_select,
   input wire logic send_violation_request,
   // Transmit symbol out
   output logic [9:0] tx_symbol,
   output logic tx_rd,
   // Receive symbol in
   input wire logic [9:0] rx_symbol,
   // Receive parallel side
   output logic [7:0] rx_byte,
   output logic rx_special,
   output logic rx_rd
);
   import scc_pkg::*;

   scc_rx_if rx_if ();

   scc_tx_mode_t mode_q, mode_d;
   logic [1:0] pos_q, pos_d;
   logic eof_q, eof_d;
   logic rd_q, rd_d;
   logic [9:0] sym_q, sym_d;
   logic ordered;
   logic cont;
   logic violate;
   logic [7:0] data_b;
   logic [7:0] k_b;

   // Ordered-set detection and position within the four-symbol set
   always_comb begin
      ordered = special_char_select && (tx_byte == SC_IDLE || tx_byte == SC_RRDY); // RULE18
      cont = ordered && ((tx_byte == SC_IDLE && mode_q == TX_IDLE) ||
                         (tx_byte == SC_RRDY && mode_q == TX_RRDY));
      violate = send_violation_request || (special_char_select && tx_byte == SC_VIOL);
      // New data or a change of code restarts the set at its comma
      pos_d = cont ? pos_q + 2'h1 : SEQ_FIRST; // RULE3
      if (violate || !ordered) begin
         mode_d = TX_DATA;
      end else if (tx_byte == SC_IDLE) begin
         mode_d = TX_IDLE;
      end else begin
         mode_d = TX_RRDY;
      end
   end

   // Symbol selection
   always_comb begin
      eof_d = 1'b0;
      data_b = tx_byte;
      sym_d = scc_encode(tx_byte, 1'b0, rd_q);
      // Cx.0 names K28.x below 8, then the four extra special characters
      k_b = tx_byte;
      if (tx_byte[7:3] == 5'h00) begin
         k_b = {tx_byte[2:0], X_K28}; // RULE17
      end else if (tx_byte[7:2] == 6'h02) begin
         k_b = K_EXTRA[tx_byte[1:0]]; // RULE17
      end
      if (violate) begin
         sym_d = rd_q ? VIOL_POS : VIOL_NEG; // RULE8
      end else if (special_char_select) begin
         case (tx_byte)
            SC_IDLE, SC_RRDY: begin
               case (pos_d)
                  SEQ_FIRST: sym_d = K285_NEG; // RULE1 RULE4
                  SEQ_SECOND: sym_d = scc_encode(D21_4, 1'b0, rd_q); // RULE2 RULE4
                  default: sym_d = (tx_byte == SC_IDLE) ? SYM_D21_5 : SYM_D10_2; // RULE2 RULE4
               endcase
            end
            SC_EOF: begin
               sym_d = rd_q ? K285_POS : K285_NEG; // RULE6
               eof_d = 1'b1;
            end
            SC_KNEG: sym_d = K285_NEG; // RULE10
            SC_KPOS: sym_d = K285_POS; // RULE12
            SC_RDERR: sym_d = rd_q ? RDERR_POS : RDERR_NEG; // RULE14
            // Remaining codes take the plain special-character table
            default: sym_d = scc_encode(k_b, 1'b1, rd_q); // RULE16 RULE17
         endcase
      end else begin
         if (eof_q) begin
            data_b[EOF_BIT] = ~rd_q; // RULE7
         end
         sym_d = scc_encode(data_b, 1'b0, rd_q);
      end
      rd_d = scc_rd_after(sym_d, rd_q); // RULE19 RULE20
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= TX_DATA;
         pos_q <= SEQ_FIRST;
         eof_q <= 1'b0;
         rd_q <= RD_RESET;
         sym_q <= SYM_RESET;
      end else if (ce) begin
         mode_q <= mode_d;
         pos_q <= pos_d;
         eof_q <= eof_d;
         rd_q <= rd_d;
         sym_q <= sym_d;
      end
   end

   assign tx_symbol = sym_q;
   assign tx_rd = rd_q;

   // Receive path
   assign rx_if.symbol = rx_symbol;
   assign rx_byte = rx_if.code;
   assign rx_special = rx_if.special;
   assign rx_rd = rx_if.rd;

   scc_rx_dec u_rx (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .rx(rx_if.dec)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_tx_single;
      ce && !send_violation_request && special_char_select && !cont &&
      (tx_byte == SC_IDLE || tx_byte == SC_RRDY) |=> tx_symbol == K285_NEG && tx_rd;
   endproperty
   a_tx_single: assert property (p_tx_single) else $error("set not opened by -K28.5"); // RULE1

   property p_tx_idle;
      ce && !violate && special_char_select && tx_byte == SC_IDLE && mode_q == TX_IDLE &&
      (pos_q == SEQ_SECOND || pos_q == SEQ_SECOND + 2'h1) |=> tx_symbol == SYM_D21_5;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("idle set tail not D21.5"); // RULE2

   property p_tx_rrdy;
      ce && !violate && special_char_select && tx_byte == SC_RRDY && mode_q == TX_RRDY &&
      (pos_q == SEQ_SECOND || pos_q == SEQ_SECOND + 2'h1) |=> tx_symbol == SYM_D10_2;
   endproperty
   a_tx_rrdy: assert property (p_tx_rrdy) else $error("ready set tail not D10.2"); // RULE4

   property p_tx_eof;
      ce && !violate && special_char_select && tx_byte == SC_EOF |=>
      tx_symbol == ($past(rd_q) ? K285_POS : K285_NEG) && tx_rd == !$past(rd_q);
   endproperty
   a_tx_eof: assert property (p_tx_eof) else $error("EOF comma polarity wrong"); // RULE6

   property p_tx_eof_bit;
      ce && eof_q && !violate && !special_char_select |=>
      tx_symbol == scc_encode({$past(tx_byte[7:6]), ~$past(rd_q), $past(tx_byte[4:0])},
                              1'b0, $past(rd_q));
   endproperty
   a_tx_eof_bit: assert property (p_tx_eof_bit) else $error("EOF follower bit wrong"); // RULE7

   property p_tx_viol;
      ce && send_violation_request |=> tx_symbol == ($past(rd_q) ? VIOL_POS : VIOL_NEG);
   endproperty
   a_tx_viol: assert property (p_tx_viol) else $error("violation symbol wrong"); // RULE8

   property p_tx_kneg;
      ce && !violate && special_char_select && tx_byte == SC_KNEG |=>
      tx_symbol == K285_NEG && tx_rd;
   endproperty
   a_tx_kneg: assert property (p_tx_kneg) else $error("forced -K28.5 wrong"); // RULE10 RULE20

   property p_tx_kpos;
      ce && !violate && special_char_select && tx_byte == SC_KPOS |=>
      tx_symbol == K285_POS && !tx_rd;
   endproperty
   a_tx_kpos: assert property (p_tx_kpos) else $error("forced +K28.5 wrong"); // RULE12 RULE20

   property p_tx_rderr;
      ce && !violate && special_char_select && tx_byte == SC_RDERR |=>
      tx_symbol == ($past(rd_q) ? RDERR_POS : RDERR_NEG) && tx_rd == !$past(rd_q);
   endproperty
   a_tx_rderr: assert property (p_tx_rderr) else $error("disparity-error symbol wrong"); // RULE14

   property p_tx_second;
      ce && !violate && cont && pos_q == SEQ_FIRST |=>
      tx_symbol == scc_encode(D21_4, 1'b0, 1'b1) && !tx_rd;
   endproperty
   a_tx_second: assert property (p_tx_second) else $error("slot two wrong"); // RULE2 RULE4

   property p_tx_break;
      ce && violate |=> mode_q == TX_DATA;
   endproperty
   a_tx_break: assert property (p_tx_break) else $error("violation kept the set"); // RULE8

   property p_tx_plain;
      ce && !violate && !special_char_select && !eof_q |=>
      tx_symbol == scc_encode($past(tx_byte), 1'b0, $past(rd_q));
   endproperty
   a_tx_plain: assert property (p_tx_plain) else $error("data not plain"); // RULE18

   property p_tx_kcode;
      ce && !violate && special_char_select && tx_byte[7:3] == 5'h00 |=>
      tx_symbol == scc_encode({$past(tx_byte[2:0]), X_K28}, 1'b1, $past(rd_q));
   endproperty
   a_tx_kcode: assert property (p_tx_kcode) else $error("Cx.0 not K28.x"); // RULE17

   property p_tx_rd;
      ce |=> tx_rd == scc_rd_after(tx_symbol, $past(rd_q));
   endproperty
   a_tx_rd: assert property (p_tx_rd) else $error("tx disparity wrong"); // RULE19 RULE20
endmodule // scc_codec

// File: sim/scc_host_model.sv
// Host-side model: drives the byte, select and violation request of the codec.
// Assumes callers invoke put just after a rising clock edge, once per byte time.
module scc_host_model (
   // Parallel host side
   output logic [7:0] tx_byte,
   output logic special_char_select,
   output logic send_violation_request
);
   timeunit 1ns;
   timeprecision 100ps;
   import scc_pkg::*;

   initial begin
      tx_byte = BYTE_RESET;
      special_char_select = 1'b0;
      send_violation_request = 1'b0;
   end

   // Defined special codes only
   function automatic logic code_defined(input logic [7:0] c);
      return (c[7:5] == 3'h0 && c[4:0] < 5'h0C) ||
             (c inside {SC_IDLE, SC_RRDY, SC_EOF, SC_VIOL, SC_KNEG, SC_KPOS, SC_RDERR});
   endfunction

   // One byte time of host request
   task automatic put(input logic [7:0] b, input logic sel, input logic viol);
      tx_byte = b;
      special_char_select = sel && code_defined(b);
      send_violation_request = viol;
   endtask
endmodule // scc_host_model

// File: sim/special_character_codec_tb.sv
// Testbench of the special-character codec: table of byte times, then freeze and reset.
// Assumes the codec and the host model; rx_symbol is driven directly by the bench.
module special_character_codec_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import scc_pkg::*;

   typedef struct {
      logic [7:0] b;
      logic sel;
      logic viol;
      logic [9:0] sym;
      logic trd;
      logic [9:0] rxs;
      logic [7:0] rb;
      logic rsp;
      logic rrd;
   } scc_row_t;

   logic clk;
   logic resetn;
   logic ce;
   logic [7:0] tx_byte;
   logic special_char_select;
   logic send_violation_request;
   logic [9:0] tx_symbol;
   logic tx_rd;
   logic [9:0] rx_symbol;
   logic [7:0] rx_byte;
   logic rx_special;
   logic rx_rd;
   int errors = 0;
   int total_checks = 0;

   // Byte times from reset: host request, symbol sent, symbol received, code out
   scc_row_t rows [29] = '{
      '{SC_IDLE, 1, 0, 10'h0FA, 1, 10'h0FA, 8'h05, 1, 1},
      '{SC_IDLE, 1, 0, 10'h2A2, 0, 10'h0FA, SC_KNEG, 1, 1},
      '{SC_IDLE, 1, 0, 10'h2AA, 0, 10'h305, SC_COMMA, 1, 0},
      '{SC_IDLE, 1, 0, 10'h2AA, 0, 10'h305, SC_KPOS, 1, 0},
      '{SC_IDLE, 1, 0, 10'h0FA, 1, 10'h278, SC_VIOL, 1, 0},
      '{SC_IDLE, 1, 0, 10'h2A2, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_IDLE, 1, 0, 10'h2AA, 0, 10'h31E, 8'hE3, 0, 1},
      '{SC_IDLE, 1, 0, 10'h2AA, 0, 10'h311, 8'hE3, 0, 0},
      '{SC_RRDY, 1, 0, 10'h0FA, 1, 10'h311, SC_RDERR, 1, 0},
      '{SC_RRDY, 1, 0, 10'h2A2, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_RRDY, 1, 0, 10'h155, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_RRDY, 1, 0, 10'h155, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_IDLE, 0, 0, 10'h279, 1, 10'h2AA, 8'hB5, 0, 0},
      '{SC_IDLE, 1, 0, 10'h0FA, 1, 10'h2AA, 8'hB5, 0, 0},
      '{SC_KNEG, 1, 0, 10'h0FA, 1, 10'h2AA, 8'hB5, 0, 0},
      '{SC_KPOS, 1, 0, 10'h305, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_KPOS, 1, 0, 10'h305, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_KNEG, 1, 0, 10'h0FA, 1, 10'h2AA, 8'hB5, 0, 0},
      '{SC_VIOL, 1, 0, 10'h187, 1, 10'h2AA, 8'hB5, 0, 0},
      '{8'h00, 0, 1, 10'h187, 1, 10'h2AA, 8'hB5, 0, 0},
      '{SC_RDERR, 1, 0, 10'h08A, 0, 10'h2AA, 8'hB5, 0, 0},
      '{8'h00, 0, 1, 10'h278, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_VIOL, 1, 0, 10'h278, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_RDERR, 1, 0, 10'h375, 1, 10'h2AA, 8'hB5, 0, 0},
      '{SC_EOF, 1, 0, 10'h305, 0, 10'h2AA, 8'hB5, 0, 0},
      '{D21_4, 0, 0, 10'h2AA, 0, 10'h2AA, 8'hB5, 0, 0},
      '{SC_EOF, 1, 0, 10'h0FA, 1, 10'h2AA, 8'hB5, 0, 0},
      '{D21_5, 0, 0, 10'h2A2, 0, 10'h2AA, 8'hB5, 0, 0},
      '{8'h07, 1, 0, 10'h0F8, 0, 10'h0F8, 8'h07, 1, 0}
   };

   scc_host_model i_scc_host_model (
      .tx_byte(tx_byte),
      .special_char_select(special_char_select),
      .send_violation_request(send_violation_request)
   );

   scc_codec i_scc_codec (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .tx_byte(tx_byte),
      .special_char_select(special_char_select),
      .send_violation_request(send_violation_request),
      .tx_symbol(tx_symbol),
      .tx_rd(tx_rd),
      .rx_symbol(rx_symbol),
      .rx_byte(rx_byte),
      .rx_special(rx_special),
      .rx_rd(rx_rd)
   );

   task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_all(input logic [9:0] s, input logic tr, input logic [7:0] rb,
                            input logic rs, input logic rr);
      check(tx_symbol, s, "tx_symbol");
      check({9'h000, tx_rd}, {9'h000, tr}, "tx_rd");
      check({2'h0, rx_byte}, {2'h0, rb}, "rx_byte");
      check({9'h000, rx_special}, {9'h000, rs}, "rx_special");
      check({9'h000, rx_rd}, {9'h000, rr}, "rx_rd");
   endtask

   task automatic conclude();
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Watchdog well past the expected run
   initial begin
      #(40 * 500);
      errors++;
      conclude();
   end

   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      rx_symbol = SYM_D21_5;
      repeat (6) @(posedge clk);
      #1 resetn = 1'b1;
      foreach (rows[i]) begin
         i_scc_host_model.put(rows[i].b, rows[i].sel, rows[i].viol);
         rx_symbol = rows[i].rxs;
         @(posedge clk);
         #1;
         check_all(rows[i].sym, rows[i].trd, rows[i].rb, rows[i].rsp, rows[i].rrd);
      end
      // Disabled clock freezes both sides
      ce = 1'b0;
      i_scc_host_model.put(SC_KPOS, 1'b1, 1'b0);
      rx_symbol = K285_NEG;
      repeat (2) @(posedge clk);
      #1;
      check_all(10'h0F8, 1'b0, 8'h07, 1'b1, 1'b0);
      ce = 1'b1;
      @(posedge clk);
      #1;
      check_all(K285_POS, 1'b0, SC_COMMA, 1'b1, 1'b1);
      // Mid-run reset returns disparity to negative
      resetn = 1'b0;
      #1;
      check_all(SYM_RESET, RD_RESET, BYTE_RESET, 1'b0, RD_RESET);
      @(posedge clk);
      #1 resetn = 1'b1;
      i_scc_host_model.put(SC_EOF, 1'b1, 1'b0);
      rx_symbol = K285_POS;
      @(posedge clk);
      #1;
      check_all(K285_NEG, 1'b1, SC_KPOS, 1'b1, 1'b0);
      conclude();
   end
endmodule // special_character_codec_tb
